// ### shared/gsr_regs.svh
// constants for the status reporting block
// Operation
// - status byte: eight bits, fixed layout
// - enabled set status bits pull request low
// - serial poll clears latched bits after return
// - request mask bit one enables, zero inhibits
// - request only with mask bit 6 set
// - status byte read command never clears bits
// - bits 0, 2-5 and 7 latch until poll
// - bit 5 from enabled event bits, masked
// - bit 7 set when log run finishes
// - bit 4 set on internal instrument error
// - bit 3 set while any alarm exists
// - bit 2 set on any range fault
// - bit 0 set on fresh reading
// - event register: eight bits, fixed layout
// - event mask stored as written with bits 1 and 6 cleared, read back
// - event register read returns then clears
// - event bit 7 set after power up
// - event bit 5 set on command fault
// - event bit 4 set on execution fault
// - event bit 3 set on device fault
// - event bit 2 set on query loss
// - event bit 0 set when operations done
`ifndef GSR_REGS_SVH
`define GSR_REGS_SVH
`define GSR_SB_NEW 0
`define GSR_SB_OVL 2
`define GSR_SB_ALM 3
`define GSR_SB_ERR 4
`define GSR_SB_ESB 5
`define GSR_SB_SRQ 6
`define GSR_SB_LOG 7
`define GSR_EV_OPC 0
`define GSR_EV_QYE 2
`define GSR_EV_DDE 3
`define GSR_EV_EXE 4
`define GSR_EV_CME 5
`define GSR_EV_PON 7
`define GSR_SB_USED 8'hBD
`define GSR_SB_LATCH 8'hBD
`define GSR_EV_USED 8'hBD
`define GSR_MASK_USED 8'hFD
`define GSR_EV_MASK_USED 8'hBD
`define GSR_RESET_VAL 8'h00
`endif

// ### shared/gsr_pkg.sv
// types for the status reporting block
package gsr_pkg;
  typedef struct packed {
    logic log_finished;
    logic instrument_error;
    logic alarm_active;
    logic sensor_over_range;
    logic temperature_over_range;
    logic sensor_under_range;
    logic temperature_under_range;
    logic fresh_reading;
  } gsr_cond_t;
  typedef struct packed {
    logic command_fault;
    logic execution_fault;
    logic device_fault;
    logic query_loss;
    logic operations_idle;
  } gsr_event_t;
  typedef struct packed {
    logic request_mask_write_cmd;
    logic event_mask_write_cmd;
    logic status_byte_read_cmd;
    logic event_flags_read_cmd;
    logic event_mask_read_cmd;
    logic request_mask_read_cmd;
    logic operation_done_cmd;
    logic [7:0] wdata;
  } gsr_cmd_t;
  typedef enum logic [1:0] {
    GSR_IDLE = 2'b00,
    GSR_POLL = 2'b01,
    GSR_DONE = 2'b11
  } gsr_poll_t;
endpackage

// ### core/gsr_status.sv
// status byte, standard event register, masks and service request
`timescale 1ns/1ps
`default_nettype none
`include "gsr_regs.svh"
module gsr_status (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire gsr_pkg::gsr_cond_t COND,
  input wire gsr_pkg::gsr_event_t EVT,
  input wire gsr_pkg::gsr_cmd_t CMD,
  input wire logic POLL_ENABLE,
  input wire logic POLL_DISABLE,
  input wire logic POLL_BYTE_TAKEN,
  output logic [7:0] POLL_BYTE,
  output logic [7:0] RDATA,
  output logic RVALID,
  output logic SRQ_O,
  output logic SRQ_OE
);
  logic [7:0] status_ff;
  logic [7:0] event_ff;
  logic [7:0] req_mask_ff;
  logic [7:0] ev_mask_ff;
  logic [7:0] rdata_ff;
  logic rvalid_ff;
  logic [7:0] poll_ff;
  logic srq_oe_ff;
  logic opc_pend_ff;
  logic pon_done_ff;
  gsr_pkg::gsr_poll_t poll_st_ff;
  gsr_pkg::gsr_poll_t nxt_poll_st;
  logic [7:0] nxt_status;
  logic [7:0] nxt_event;
  logic [7:0] stat_set;
  logic [7:0] ev_set;
  logic [7:0] status_view;
  logic [7:0] rd_mux;
  logic esb_active;
  logic srq_want;
  logic poll_clear;
  logic range_fault;
  logic rd_any;
  logic opc_fire;

  // range faults from any input fold into one overload cause
  assign range_fault = COND.sensor_over_range | COND.temperature_over_range |
    COND.sensor_under_range | COND.temperature_under_range;
  // summary bit from enabled event bits
  assign esb_active = |(event_ff & ev_mask_ff & `GSR_EV_USED);
  // operation complete fires once pending work is finished
  assign opc_fire = (CMD.operation_done_cmd | opc_pend_ff) & EVT.operations_idle;

  // status set causes per bit
  assign stat_set[`GSR_SB_NEW] = COND.fresh_reading;
  assign stat_set[1] = 1'b0;
  assign stat_set[`GSR_SB_OVL] = range_fault;
  assign stat_set[`GSR_SB_ALM] = COND.alarm_active;
  assign stat_set[`GSR_SB_ERR] = COND.instrument_error;
  assign stat_set[`GSR_SB_ESB] = esb_active;
  assign stat_set[`GSR_SB_SRQ] = 1'b0;
  assign stat_set[`GSR_SB_LOG] = COND.log_finished;

  // event set causes per bit
  assign ev_set[`GSR_EV_OPC] = opc_fire;
  assign ev_set[1] = 1'b0;
  assign ev_set[`GSR_EV_QYE] = EVT.query_loss;
  assign ev_set[`GSR_EV_DDE] = EVT.device_fault;
  assign ev_set[`GSR_EV_EXE] = EVT.execution_fault;
  assign ev_set[`GSR_EV_CME] = EVT.command_fault;
  assign ev_set[6] = 1'b0;
  assign ev_set[`GSR_EV_PON] = ~pon_done_ff;

  // service request wanted when any enabled latched bit is set and bit 6 enables
  assign srq_want = req_mask_ff[`GSR_SB_SRQ] &
    (|(status_ff & req_mask_ff & `GSR_SB_LATCH));
  // visible status byte with request bit folded in
  assign status_view = (status_ff & `GSR_SB_LATCH) |
    ({7'h00, srq_want} << `GSR_SB_SRQ);

  // poll clear happens once the controller took the byte
  assign poll_clear = (poll_st_ff == gsr_pkg::GSR_POLL) & POLL_BYTE_TAKEN;
  // set wins over poll clear for new causes in the same cycle
  assign nxt_status = ((poll_clear ? 8'h00 : status_ff) | stat_set) & `GSR_SB_LATCH;
  // set wins over read clear
  assign nxt_event = ((CMD.event_flags_read_cmd ? 8'h00 : event_ff) | ev_set) &
    `GSR_EV_USED;

  // read data selection
  assign rd_any = CMD.status_byte_read_cmd | CMD.event_flags_read_cmd |
    CMD.event_mask_read_cmd | CMD.request_mask_read_cmd;
  assign rd_mux = CMD.status_byte_read_cmd ? status_view :
    CMD.event_flags_read_cmd ? (event_ff & `GSR_EV_USED) :
    CMD.event_mask_read_cmd ? ev_mask_ff :
    CMD.request_mask_read_cmd ? req_mask_ff : 8'h00;

  // serial poll sequencing: enable, byte taken, disable
  always_comb begin
    nxt_poll_st = poll_st_ff;
    case (poll_st_ff)
      gsr_pkg::GSR_IDLE: begin
        if (POLL_ENABLE) begin
          nxt_poll_st = gsr_pkg::GSR_POLL;
        end
      end
      gsr_pkg::GSR_POLL: begin
        if (POLL_DISABLE) begin
          nxt_poll_st = gsr_pkg::GSR_IDLE;
        end else if (POLL_BYTE_TAKEN) begin
          nxt_poll_st = gsr_pkg::GSR_DONE;
        end
      end
      gsr_pkg::GSR_DONE: begin
        if (POLL_DISABLE) begin
          nxt_poll_st = gsr_pkg::GSR_IDLE;
        end
      end
      default: begin
        nxt_poll_st = gsr_pkg::GSR_IDLE;
      end
    endcase
  end

  // status and event registers
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      status_ff <= `GSR_RESET_VAL;
      event_ff <= `GSR_RESET_VAL;
      pon_done_ff <= 1'b0;
      opc_pend_ff <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      event_ff <= nxt_event;
      pon_done_ff <= 1'b1;
      opc_pend_ff <= (CMD.operation_done_cmd | opc_pend_ff) & ~EVT.operations_idle;
    end
  end

  // enable masks keep the used bits of what the command wrote
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      req_mask_ff <= `GSR_RESET_VAL;
      ev_mask_ff <= `GSR_RESET_VAL;
    end else begin
      if (CMD.request_mask_write_cmd) begin
        req_mask_ff <= CMD.wdata & `GSR_MASK_USED;
      end
      if (CMD.event_mask_write_cmd) begin
        ev_mask_ff <= CMD.wdata & `GSR_EV_MASK_USED;
      end
    end
  end

  // outputs from flops
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      poll_st_ff <= gsr_pkg::GSR_IDLE;
      poll_ff <= 8'h00;
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
      srq_oe_ff <= 1'b0;
    end else begin
      poll_st_ff <= nxt_poll_st;
      poll_ff <= status_view;
      rdata_ff <= rd_any ? rd_mux : rdata_ff;
      rvalid_ff <= rd_any;
      srq_oe_ff <= srq_want;
    end
  end

  assign POLL_BYTE = poll_ff;
  assign RDATA = rdata_ff;
  assign RVALID = rvalid_ff;
  assign SRQ_O = 1'b0; // open-drain: only ever pulls low
  assign SRQ_OE = srq_oe_ff;

  property p_srq_follows;
    @(posedge REF_CLK) disable iff (!RST_N)
    srq_want |=> SRQ_OE;
  endproperty
  a_srq_follows: assert property (p_srq_follows) else $error("srq not driven");

  property p_srq_gate;
    @(posedge REF_CLK) disable iff (!RST_N)
    !req_mask_ff[`GSR_SB_SRQ] |=> !SRQ_OE;
  endproperty
  a_srq_gate: assert property (p_srq_gate) else $error("srq without enable");

  property p_poll_clear;
    @(posedge REF_CLK) disable iff (!RST_N)
    (poll_clear && stat_set == 8'h00) |=> (status_ff == 8'h00);
  endproperty
  a_poll_clear: assert property (p_poll_clear) else $error("poll did not clear");

  property p_read_keeps;
    @(posedge REF_CLK) disable iff (!RST_N)
    (CMD.status_byte_read_cmd && !poll_clear) |=>
      ((status_ff & $past(status_ff)) == $past(status_ff));
  endproperty
  a_read_keeps: assert property (p_read_keeps) else $error("status read cleared bits");

  property p_latch;
    @(posedge REF_CLK) disable iff (!RST_N)
    (!poll_clear) |=> ((status_ff & $past(status_ff)) == $past(status_ff));
  endproperty
  a_latch: assert property (p_latch) else $error("status bit dropped");

  property p_esb;
    @(posedge REF_CLK) disable iff (!RST_N)
    (|(event_ff & ev_mask_ff)) |=> status_ff[`GSR_SB_ESB];
  endproperty
  a_esb: assert property (p_esb) else $error("summary bit missing");

  sequence s_mask_wr;
    CMD.event_mask_write_cmd ##1 !CMD.event_mask_write_cmd;
  endsequence
  property p_mask_store;
    @(posedge REF_CLK) disable iff (!RST_N)
    s_mask_wr |-> (ev_mask_ff == ($past(CMD.wdata) & `GSR_EV_MASK_USED));
  endproperty
  a_mask_store: assert property (p_mask_store) else $error("event mask not stored");

  property p_ev_clear;
    @(posedge REF_CLK) disable iff (!RST_N)
    (CMD.event_flags_read_cmd && ev_set == 8'h00) |=>
      (event_ff == 8'h00) && (RDATA == $past(event_ff));
  endproperty
  a_ev_clear: assert property (p_ev_clear) else $error("event read wrong");

  property p_unused;
    @(posedge REF_CLK) disable iff (!RST_N)
    (status_ff[1] == 1'b0) && (event_ff[6] == 1'b0) && (event_ff[1] == 1'b0) &&
    (ev_mask_ff[1] == 1'b0) && (ev_mask_ff[6] == 1'b0) && (req_mask_ff[1] == 1'b0);
  endproperty
  a_unused: assert property (p_unused) else $error("unused bit set");

  property p_pon;
    @(posedge REF_CLK) disable iff (!RST_N)
    $rose(RST_N) |=> event_ff[`GSR_EV_PON];
  endproperty
  a_pon: assert property (p_pon) else $error("power up flag missing");

  // the polled byte is the visible status byte one cycle late
  property p_poll_byte;
    @(posedge REF_CLK) disable iff (!RST_N)
    RST_N |=> (POLL_BYTE == $past(status_view));
  endproperty
  a_poll_byte: assert property (p_poll_byte) else $error("polled byte stale");

  // serial poll enable opens a poll from idle
  sequence s_poll_open;
    (poll_st_ff == gsr_pkg::GSR_IDLE) && POLL_ENABLE;
  endsequence
  property p_poll_open;
    @(posedge REF_CLK) disable iff (!RST_N)
    s_poll_open |=> (poll_st_ff == gsr_pkg::GSR_POLL);
  endproperty
  a_poll_open: assert property (p_poll_open) else $error("poll not opened");

  // the first byte taken moves the poll to done
  sequence s_poll_take;
    (poll_st_ff == gsr_pkg::GSR_POLL) && POLL_BYTE_TAKEN && !POLL_DISABLE;
  endsequence
  property p_poll_take;
    @(posedge REF_CLK) disable iff (!RST_N)
    s_poll_take |=> (poll_st_ff == gsr_pkg::GSR_DONE);
  endproperty
  a_poll_take: assert property (p_poll_take) else $error("poll byte not retired");

  // serial poll disable always returns to idle
  property p_poll_close;
    @(posedge REF_CLK) disable iff (!RST_N)
    (POLL_DISABLE && (poll_st_ff != gsr_pkg::GSR_IDLE)) |=> (poll_st_ff == gsr_pkg::GSR_IDLE);
  endproperty
  a_poll_close: assert property (p_poll_close) else $error("poll not closed");

  // every read strobe is answered by a valid pulse
  property p_rvalid_pulse;
    @(posedge REF_CLK) disable iff (!RST_N)
    rd_any |=> RVALID;
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read not answered");

  // no valid pulse without a read strobe
  property p_rvalid_quiet;
    @(posedge REF_CLK) disable iff (!RST_N)
    (RST_N && !rd_any) |=> !RVALID;
  endproperty
  a_rvalid_quiet: assert property (p_rvalid_quiet) else $error("spurious read valid");

  // read data holds between reads
  property p_rdata_hold;
    @(posedge REF_CLK) disable iff (!RST_N)
    (RST_N && !rd_any) |=> $stable(RDATA);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  // status read returns the visible status byte
  property p_status_read;
    @(posedge REF_CLK) disable iff (!RST_N)
    CMD.status_byte_read_cmd |=> (RDATA == $past(status_view));
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  // event mask query returns the stored mask
  property p_mask_read;
    @(posedge REF_CLK) disable iff (!RST_N)
    (CMD.event_mask_read_cmd && !CMD.status_byte_read_cmd && !CMD.event_flags_read_cmd) |=>
      (RDATA == $past(ev_mask_ff));
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("event mask read wrong");

  // request mask query returns the stored mask
  property p_req_read;
    @(posedge REF_CLK) disable iff (!RST_N)
    (CMD.request_mask_read_cmd && !CMD.status_byte_read_cmd &&
      !CMD.event_flags_read_cmd && !CMD.event_mask_read_cmd) |=>
      (RDATA == $past(req_mask_ff));
  endproperty
  a_req_read: assert property (p_req_read) else $error("request mask read wrong");

  // request mask keeps what a write strobe carried, with bit 1 cleared
  sequence s_req_wr;
    CMD.request_mask_write_cmd ##1 !CMD.request_mask_write_cmd;
  endsequence
  property p_req_store;
    @(posedge REF_CLK) disable iff (!RST_N)
    s_req_wr |-> (req_mask_ff == ($past(CMD.wdata) & `GSR_MASK_USED));
  endproperty
  a_req_store: assert property (p_req_store) else $error("request mask not stored");

  // operation complete lands in event bit 0
  property p_opc_set;
    @(posedge REF_CLK) disable iff (!RST_N)
    opc_fire |=> event_ff[`GSR_EV_OPC];
  endproperty
  a_opc_set: assert property (p_opc_set) else $error("operation complete lost");

  // a busy device arms the pending operation complete
  property p_opc_arm;
    @(posedge REF_CLK) disable iff (!RST_N)
    (CMD.operation_done_cmd && !EVT.operations_idle) |=> opc_pend_ff;
  endproperty
  a_opc_arm: assert property (p_opc_arm) else $error("operation complete not armed");

  // every event cause is latched, even against a read clear
  property p_ev_set;
    @(posedge REF_CLK) disable iff (!RST_N)
    RST_N |=> ((event_ff & $past(ev_set)) == $past(ev_set));
  endproperty
  a_ev_set: assert property (p_ev_set) else $error("event cause lost");

  // every status cause is latched, even against a poll clear
  property p_stat_set;
    @(posedge REF_CLK) disable iff (!RST_N)
    RST_N |=> ((status_ff & $past(stat_set)) == $past(stat_set));
  endproperty
  a_stat_set: assert property (p_stat_set) else $error("status cause lost");

  // request pin released once nothing asks for it
  property p_srq_drop;
    @(posedge REF_CLK) disable iff (!RST_N)
    !srq_want |=> !SRQ_OE;
  endproperty
  a_srq_drop: assert property (p_srq_drop) else $error("srq held without cause");

  // summary bit never rises from masked events
  property p_esb_masked;
    @(posedge REF_CLK) disable iff (!RST_N)
    (RST_N && !esb_active && !status_ff[`GSR_SB_ESB]) |=> !status_ff[`GSR_SB_ESB];
  endproperty
  a_esb_masked: assert property (p_esb_masked) else $error("summary bit from masked event");

  // no request unless an enabled latched bit is set
  property p_srq_needs;
    @(posedge REF_CLK) disable iff (!RST_N)
    (RST_N && !(|(status_ff & req_mask_ff & `GSR_SB_LATCH))) |=> !SRQ_OE;
  endproperty
  a_srq_needs: assert property (p_srq_needs) else $error("srq with no enabled bit");
endmodule // gsr_status
`default_nettype wire

// ### sim/gsr_ctrl_model.sv
// bus controller model that runs one serial poll on request
`timescale 1ns/1ps
`default_nettype none
module gsr_ctrl_model (
  input wire logic clk,
  input wire logic go,
  input wire logic [7:0] poll_byte,
  output logic spe,
  output logic spd,
  output logic taken,
  output logic [7:0] got,
  output logic busy
);
  logic [2:0] step_ff = 3'h0;
  // poll enable, take one byte, then poll disable
  assign spe = step_ff == 3'h1;
  assign taken = step_ff == 3'h3;
  assign spd = step_ff == 3'h5;
  assign busy = step_ff != 3'h0;
  // step counter; the byte is kept at the edge where it is taken
  always_ff @(posedge clk) begin
    if (go || busy) step_ff <= (step_ff == 3'h6) ? 3'h0 : step_ff + 3'h1;
    if (taken) got <= poll_byte;
  end
endmodule // gsr_ctrl_model
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench for the status reporting block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  gsr_pkg::gsr_cond_t cond = '0;
  gsr_pkg::gsr_event_t evt = 5'h01;
  gsr_pkg::gsr_cmd_t cmd = '0;
  logic go = 1'b0;
  logic spe, spd, taken, busy, rvalid, srq_o, srq_oe;
  logic [7:0] poll_byte, rdata, got;
  logic [31:0] seed = 32'h00004DB1;
  int err_total = 0;
  int n_checks = 0;
  // free-running clock
  always #4 clk = ~clk;
  gsr_status u_dut (.REF_CLK(clk), .RST_N(rst_n), .COND(cond), .EVT(evt), .CMD(cmd),
    .POLL_ENABLE(spe), .POLL_DISABLE(spd), .POLL_BYTE_TAKEN(taken), .POLL_BYTE(poll_byte),
    .RDATA(rdata), .RVALID(rvalid), .SRQ_O(srq_o), .SRQ_OE(srq_oe));
  gsr_ctrl_model u_ctrl (.clk(clk), .go(go), .poll_byte(poll_byte), .spe(spe), .spd(spd),
    .taken(taken), .got(got), .busy(busy));
  // xorshift random source
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // status bits expected from a set of causes
  function automatic logic [7:0] sb_of(input logic [7:0] c);
    return {c[7], 2'b00, c[6], c[5], |c[4:1], 1'b0, c[0]};
  endfunction
  task automatic chk(input logic [7:0] v, input logic [7:0] e);
    n_checks++;
    if (v !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, v, e);
    end
  endtask
  // read: 0 status, 1 event flags, 2 event mask, 3 request mask
  task automatic rd(input int sel, input logic [7:0] e);
    int k;
    @(posedge clk);
    cmd.status_byte_read_cmd <= sel == 0;
    cmd.event_flags_read_cmd <= sel == 1;
    cmd.event_mask_read_cmd <= sel == 2;
    cmd.request_mask_read_cmd <= sel == 3;
    @(posedge clk);
    cmd <= '0;
    for (k = 0; k < 4 && rvalid !== 1'b1; k++) @(negedge clk);
    chk({7'h00, rvalid}, 8'h01);
    chk(rdata, e);
  endtask
  task automatic wr(input bit ev, input logic [7:0] v);
    @(posedge clk);
    cmd.event_mask_write_cmd <= ev;
    cmd.request_mask_write_cmd <= !ev;
    cmd.wdata <= v;
    @(posedge clk);
    cmd <= '0;
  endtask
  // one-cycle causes, then time for latch and request flop
  task automatic pulse(input logic [7:0] c, input logic [4:0] e);
    @(posedge clk);
    cond <= c;
    evt <= {e[4:1], evt.operations_idle};
    @(posedge clk);
    cond <= '0;
    evt <= {4'h0, evt.operations_idle};
    repeat (3) @(negedge clk);
  endtask
  task automatic poll(input logic [7:0] e);
    int k;
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(negedge clk);
    for (k = 0; k < 20 && busy !== 1'b0; k++) @(negedge clk);
    chk(got, e);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    #200000;
    err_total++;
    complete_run();
  end
  // main sequence
  initial begin
    int i;
    logic [7:0] c;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(1, 8'h80);
    rd(1, 8'h00);
    for (i = 0; i < 4; i++) begin
      seed = xs(seed);
      wr(1'b1, seed[7:0]);
      rd(2, seed[7:0] & 8'hBD);
      wr(1'b0, seed[7:0]);
      rd(3, seed[7:0] & 8'hFD);
    end
    wr(1'b1, 8'h00);
    wr(1'b0, 8'h00);
    $display("mask test done");
    for (i = 0; i < 12; i++) begin
      seed = xs(seed);
      c = (i < 8) ? 8'h01 << i : seed[7:0];
      pulse(c, 5'h00);
      rd(0, sb_of(c));
      rd(0, sb_of(c));
      poll(sb_of(c));
      rd(0, 8'h00);
    end
    $display("status test done");
    for (i = 1; i < 5; i++) begin
      pulse(8'h00, 5'h01 << i);
      rd(1, 8'h02 << i);
      rd(1, 8'h00);
    end
    @(posedge clk);
    evt.operations_idle <= 1'b0;
    cmd.operation_done_cmd <= 1'b1;
    @(posedge clk);
    cmd <= '0;
    rd(1, 8'h00);
    @(posedge clk);
    evt.operations_idle <= 1'b1;
    repeat (3) @(posedge clk);
    rd(1, 8'h01);
    $display("event test done");
    wr(1'b1, 8'h20);
    wr(1'b0, 8'h60);
    pulse(8'h00, 5'h10);
    chk({7'h00, srq_oe}, 8'h01);
    chk({7'h00, srq_o}, 8'h00);
    rd(0, 8'h60);
    rd(1, 8'h20);
    poll(8'h60);
    chk({7'h00, srq_oe}, 8'h00);
    wr(1'b0, 8'h01);
    pulse(8'h01, 5'h00);
    chk({7'h00, srq_oe}, 8'h00);
    wr(1'b0, 8'h41);
    repeat (2) @(negedge clk);
    chk({7'h00, srq_oe}, 8'h01);
    wr(1'b0, 8'h40);
    repeat (2) @(negedge clk);
    chk({7'h00, srq_oe}, 8'h00);
    $display("request test done");
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
